//--- tcr_cfg.svh
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH
// Register byte offsets
`define TCR_OFF_NVOL 4'h0
`define TCR_OFF_VOL 4'h4
`define TCR_OFF_STAT 4'h8
// Field positions in the configuration byte
`define TCR_LAT_HI 7
`define TCR_LAT_LO 6
`define TCR_BLK_BIT 5
`define TCR_BUF_BIT 4
// Upper four bits are the live fields; the low nibble stays zero
`define TCR_FIELD_MASK 8'hF0
`define TCR_FACTORY_DEF 8'h00
// Buffer sizes in bytes
`define TCR_BUF_SMALL 10'h100
`define TCR_BUF_LARGE 10'h200
// AXI responses
`define TCR_RESP_OKAY 2'h0
`define TCR_RESP_SLVERR 2'h2
`endif

//--- tcr_pkg.sv
package tcr_pkg;
  // Transaction request from the command decoder
  typedef struct packed {
    logic erase_req;
    logic erase_blank;
    logic prog_byte;
    logic prog_start;
    logic [1:0] opcode_class;
  } tcr_req_t;
  // Decisions returned to the command decoder
  typedef struct packed {
    logic erase_go;
    logic erase_skip;
    logic [4:0] dummy_cycles;
    logic [8:0] buf_index;
  } tcr_ctl_t;
  typedef enum logic [1:0] {
    TCR_W_IDLE = 2'b00,
    TCR_W_RESP = 2'b01
  } tcr_wstate_t;
endpackage

//--- tcr_top.sv
// Functional notes
// - Latency field sets register read dummy cycles
// - Dummy count depends on code and opcode
// - Blank check on: skip erase if blank
// - Blank check off: always erase
// - Buffer bit selects 256 or 512 bytes
// - Program write position wraps inside buffer
// - Both copies readable and writable
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`include "tcr_cfg.svh"
module tcr_top
  import tcr_pkg::*;
#(
  parameter int LAT_W = 5
) (
  input wire logic clk, // 10 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic [7:0] nvol_init, // Stored non-volatile image
  input wire tcr_req_t req, // Request from command decoder
  output tcr_ctl_t ctl, // Decisions to command decoder
  output logic nvol_wr_pulse, // Non-volatile copy updated
  input wire logic [3:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [3:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  // Refuse a dummy count too narrow for the latency table
  if (LAT_W < 5) begin : g_bad_lat_w
    $error("LAT_W too small");
  end

  // Dummy cycle table: code x opcode class
  function automatic logic [4:0] lat_lookup(input logic [1:0] code, input logic [1:0] cls);
    logic [4:0] base;
    base = 5'h0;
    case (cls)
      2'h0: base = 5'h0; // single-line SDR
      2'h1: base = 5'h4; // octal SDR
      2'h2: base = 5'h6; // octal DDR
      default: base = 5'h8; // non-volatile read
    endcase
    lat_lookup = base + {3'h0, code};
  endfunction

  tcr_wstate_t wst_r, wst_nxt;
  logic [7:0] nvol_r, nvol_nxt, vol_r, vol_nxt;
  logic boot_r, boot_nxt;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [3:0] awaddr_r, awaddr_nxt;
  logic [7:0] wbyte_r, wbyte_nxt;
  logic wen_r, wen_nxt;
  logic [1:0] bresp_nxt;
  logic bvalid_nxt, awready_nxt, wready_nxt, nvpulse_nxt;
  logic arready_nxt, rvalid_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;
  tcr_ctl_t ctl_nxt;
  logic [8:0] idx_nxt;
  logic [9:0] buf_len;

  // Buffer length from the live copy
  assign buf_len = vol_r[`TCR_BUF_BIT] ? `TCR_BUF_LARGE : `TCR_BUF_SMALL;

  // Write channel and register update
  always_comb begin
    wst_nxt = wst_r;
    nvol_nxt = nvol_r;
    vol_nxt = vol_r;
    boot_nxt = 1'b0;
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wbyte_nxt = wbyte_r;
    wen_nxt = wen_r;
    bresp_nxt = s_axi_bresp;
    bvalid_nxt = s_axi_bvalid;
    nvpulse_nxt = 1'b0;
    if (boot_r) begin
      nvol_nxt = nvol_init & `TCR_FIELD_MASK;
      vol_nxt = nvol_init & `TCR_FIELD_MASK;
    end
    case (wst_r)
      TCR_W_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_nxt = 1'b1;
          awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_nxt = 1'b1;
          wbyte_nxt = s_axi_wdata[7:0];
          wen_nxt = s_axi_wstrb[0];
        end
        if (aw_held_r && w_held_r) begin
          aw_held_nxt = 1'b0;
          w_held_nxt = 1'b0;
          bvalid_nxt = 1'b1;
          bresp_nxt = `TCR_RESP_OKAY;
          case (awaddr_r)
            `TCR_OFF_NVOL: begin
              if (wen_r) begin
                nvol_nxt = wbyte_r & `TCR_FIELD_MASK;
                nvpulse_nxt = 1'b1;
              end
            end
            `TCR_OFF_VOL: begin
              if (wen_r) vol_nxt = wbyte_r & `TCR_FIELD_MASK;
            end
            `TCR_OFF_STAT: bresp_nxt = `TCR_RESP_OKAY;
            default: bresp_nxt = `TCR_RESP_SLVERR;
          endcase
          wst_nxt = TCR_W_RESP;
        end
      end
      TCR_W_RESP: begin
        if (s_axi_bready) begin
          bvalid_nxt = 1'b0;
          wst_nxt = TCR_W_IDLE;
        end
      end
      default: wst_nxt = TCR_W_IDLE;
    endcase
    awready_nxt = (wst_nxt == TCR_W_IDLE) && !aw_held_nxt;
    wready_nxt = (wst_nxt == TCR_W_IDLE) && !w_held_nxt;
  end

  // Read channel
  always_comb begin
    arready_nxt = s_axi_arready || boot_r; // Open the read port once the copies load
    rvalid_nxt = s_axi_rvalid;
    rdata_nxt = s_axi_rdata;
    rresp_nxt = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = `TCR_RESP_OKAY;
      case (s_axi_araddr)
        `TCR_OFF_NVOL: rdata_nxt = {24'h0, nvol_r};
        `TCR_OFF_VOL: rdata_nxt = {24'h0, vol_r};
        `TCR_OFF_STAT: rdata_nxt = {23'h0, ctl.buf_index};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = `TCR_RESP_SLVERR;
        end
      endcase
    end
  end

  // Transaction decisions from the volatile copy
  always_comb begin
    ctl_nxt = ctl;
    ctl_nxt.dummy_cycles = lat_lookup(vol_r[`TCR_LAT_HI:`TCR_LAT_LO], req.opcode_class);
    ctl_nxt.erase_go = 1'b0;
    ctl_nxt.erase_skip = 1'b0;
    if (req.erase_req) begin
      if (vol_r[`TCR_BLK_BIT] && req.erase_blank) begin
        ctl_nxt.erase_skip = 1'b1;
      end else begin
        ctl_nxt.erase_go = 1'b1;
      end
    end
    idx_nxt = ctl.buf_index;
    if (req.prog_start) begin
      idx_nxt = 9'h0;
    end else if (req.prog_byte) begin
      if ({1'b0, ctl.buf_index} + 10'h1 >= buf_len) idx_nxt = 9'h0;
      else idx_nxt = ctl.buf_index + 9'h1;
    end
    ctl_nxt.buf_index = idx_nxt;
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wst_r <= TCR_W_IDLE;
      nvol_r <= `TCR_FACTORY_DEF;
      vol_r <= `TCR_FACTORY_DEF;
      boot_r <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 4'h0;
      wbyte_r <= 8'h0;
      wen_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
      nvol_wr_pulse <= 1'b0;
      ctl <= '0;
    end else if (ce) begin
      wst_r <= wst_nxt;
      nvol_r <= nvol_nxt;
      vol_r <= vol_nxt;
      boot_r <= boot_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wbyte_r <= wbyte_nxt;
      wen_r <= wen_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready <= wready_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rdata <= rdata_nxt;
      s_axi_rresp <= rresp_nxt;
      nvol_wr_pulse <= nvpulse_nxt;
      ctl <= ctl_nxt;
    end
  end
endmodule

//--- tcr_properties.sv
module tcr_properties
  import tcr_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic ce, // Enable
  input wire tcr_req_t req, // Requests
  input wire tcr_ctl_t ctl, // Decisions
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic s_axi_rvalid // R valid
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] BASE [4] = '{5'h00, 5'h04, 5'h06, 5'h08};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Erase answers
  a_erase_once: assert property (ce && req.erase_req |=> ctl.erase_go ^ ctl.erase_skip)
    else $error("erase answer wrong");
  a_erase_dirty: assert property (ce && req.erase_req && !req.erase_blank |=> ctl.erase_go)
    else $error("dirty sector not erased");
  // Latency within code range above base
  a_dummy_sum: assert property (ce |=> ctl.dummy_cycles - BASE[$past(req.opcode_class)] < 5'h04)
    else $error("dummy count wrong");
  // Program position
  a_buf_start: assert property (ce && req.prog_start |=> ctl.buf_index == 9'h000)
    else $error("position not cleared");
  a_buf_step: assert property (ce && req.prog_byte && !req.prog_start |=>
    ctl.buf_index == $past(ctl.buf_index) + 9'h001 ||
    ($past(ctl.buf_index) == 9'h0FF && ctl.buf_index == 9'h000))
    else $error("position step wrong");
  a_buf_hold: assert property (ce && !req.prog_byte && !req.prog_start |=> $stable(ctl.buf_index))
    else $error("position moved");
  // Register access timing
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
endmodule
bind tcr_top tcr_properties chk_u (
  .clk(clk),
  .rst_n(rst_n),
  .ce(ce),
  .req(req),
  .ctl(ctl),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid)
);

//--- tcr_host.sv
module tcr_host
  import tcr_pkg::*;
(
  input wire logic clk, // Clock
  output tcr_req_t req // Requests
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // Erase; blank status inverted after the request
  task automatic erase(input logic blank);
    @(posedge clk);
    req.erase_req <= 1'h1;
    req.erase_blank <= blank;
    @(posedge clk);
    req.erase_req <= 1'h0;
    req.erase_blank <= ~blank;
  endtask
  // Program burst of n bytes
  task automatic prog(input int n);
    @(posedge clk);
    req.prog_start <= 1'h1;
    @(posedge clk);
    req.prog_start <= 1'h0;
    repeat (n) begin
      req.prog_byte <= 1'h1;
      @(posedge clk);
    end
    req.prog_byte <= 1'h0;
  endtask
  task automatic cls(input logic [1:0] c);
    @(posedge clk);
    req.opcode_class <= c;
  endtask
endmodule

//--- tb_top.sv
module tb_top
  import tcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] nvol_init = 8'hA5;
  tcr_req_t req;
  tcr_ctl_t ctl;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic ce = 1'h1;
  logic nvol_wr_pulse;
  int nvpulse_cnt = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int error_cnt = 0, n_tests = 0;
  logic [7:0] vals [3] = '{8'h70, 8'hC5, 8'h20};
  logic [4:0] base [4] = '{5'h00, 5'h04, 5'h06, 5'h08};
  tcr_top dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .nvol_init(nvol_init),
    .req(req),
    .ctl(ctl),
    .nvol_wr_pulse(nvol_wr_pulse),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  tcr_host host_u (.clk(clk), .req(req));
  always #50 clk = ~clk;
  // Count strobes from the non-volatile copy
  always @(posedge clk) begin
    if (nvol_wr_pulse === 1'h1) nvpulse_cnt <= nvpulse_cnt + 1;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus write; valids dropped as each channel is taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask
  // Every opcode class against one latency code
  task automatic dum(input logic [1:0] code);
    for (int c = 0; c < 4; c++) begin
      host_u.cls(c[1:0]);
      @(posedge clk);
      #1 chk("dummy_cycles", 32'(base[c] + code), 32'(ctl.dummy_cycles));
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    rd(4'h0, 32'hA0, 2'h0);
    rd(4'h4, 32'hA0, 2'h0);
    dum(2'h2);
    $display("reset test done");
    foreach (vals[i]) begin
      wr(4'h4, {24'h0, vals[i]}, 2'h0);
      rd(4'h4, {24'h0, vals[i] & 8'hF0}, 2'h0);
      dum(vals[i][7:6]);
      host_u.erase(1'h1);
      #1 chk("erase_skip", 32'(vals[i][5]), 32'(ctl.erase_skip));
      chk("erase_go", 32'(!vals[i][5]), 32'(ctl.erase_go));
      host_u.erase(1'h0);
      #1 chk("erase_go", 32'h1, 32'(ctl.erase_go));
      host_u.prog(vals[i][4] ? 772 : 260);
      rd(4'h8, vals[i][4] ? 32'h104 : 32'h4, 2'h0);
      $display("config %h test done", vals[i]);
    end
    wr(4'h0, 32'h55, 2'h0);
    rd(4'h0, 32'h50, 2'h0);
    rd(4'h4, 32'h20, 2'h0);
    s_axi_wstrb <= 4'hE;
    wr(4'h4, 32'hFF, 2'h0);
    rd(4'h4, 32'h20, 2'h0);
    s_axi_wstrb <= 4'hF;
    wr(4'hC, 32'hFF, 2'h2);
    rd(4'hC, 32'h0, 2'h2);
    $display("copies test done");
    ce <= 1'h0;
    host_u.prog(3);
    ce <= 1'h1;
    rd(4'h8, 32'h4, 2'h0);
    chk("nvol_wr_pulse", 32'h1, 32'(nvpulse_cnt));
    $display("enable test done");
    nvol_init <= 8'h3C;
    rst_n <= 1'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    rd(4'h4, 32'h30, 2'h0);
    rd(4'h0, 32'h30, 2'h0);
    $display("reload test done");
    end_sim;
  end
  // Watchdog, about fourteen times the expected run
  initial begin
    #2000000;
    error_cnt++;
    end_sim;
  end
endmodule
